// File: curve_acq_defines.svh
// Constants for the curve buffer acquisition trigger block.
// Assumes a single system clock; included by bare name.
`ifndef CURVE_ACQ_DEFINES_SVH
`define CURVE_ACQ_DEFINES_SVH

// System clock period
`define CLK_PERIOD_NS 100
// One microsecond, the storage interval unit
`define US_NS 1000
`define US_CYCLES (`US_NS / `CLK_PERIOD_NS)
// Storage interval floors in microseconds
`define MIN_INTERVAL_FAST_US 1
`define MIN_INTERVAL_STD_US 1000
// Internal auxiliary converter tick, 1 kHz
`define AUX_TICK_NS 1000000
`define AUX_TICK_CYCLES (`AUX_TICK_NS / `CLK_PERIOD_NS)
// Burst conversion spacing, 5 us per point
`define BURST_NS 5000
`define BURST_CYCLES (`BURST_NS / `CLK_PERIOD_NS)
// Width of one trigger output pulse
`define PULSE_NS 1000
`define PULSE_CYCLES (`PULSE_NS / `CLK_PERIOD_NS)
// Sweep link codes and highest triggered mode
`define LINK_FIRST 4'h9
`define LINK_LAST 4'hb
`define BUFFER_TRIGGER_INPUT_MODE_MAX 4'h9

`endif

// File: curve_acq_pkg.sv
// Types shared by the curve buffer acquisition trigger block.
// Assumes nothing of its surroundings.
package curve_acq_pkg;

    // Acquisition state, Gray coded along idle, armed, run
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ARMED = 2'h1,
        ST_RUN = 2'h3
    } acq_state_t;

    // How a run comes to an end
    typedef enum logic [1:0] {
        STOP_COUNT = 2'h0,
        STOP_HALT = 2'h1,
        STOP_RISE = 2'h2,
        STOP_FALL = 2'h3
    } stop_kind_t;

endpackage

// File: curve_buffer_acquisition_trigger.sv
// Curve buffer acquisition trigger: sample FIFO and acquisition control.
// Assumes commands are one-cycle pulses on CLOCK, trigger pins are async,
// and the buffer memory takes one write per cycle while MEM_READY is high.
//
// Overview of operation
// - Take-once starts at the current buffer position and stops at the point count.
// - A linked sweep (codes 9 to 11) starts together with acquisition.
// - Continuous code 0 stops on halt, 1 on rising, 2 on falling edge.
// - Continuous without a parameter acts as triggered mode 0.
// - The write pointer wraps so new points overwrite the oldest.
// - Triggered modes 0, 2, 4, 6, 8 and 9 arm and wait for the chosen input edge.
// - The trigger starts a run or takes a point, on either edge.
// - A run ends at the point count, on halt, or on a chosen edge.
// - Triggered modes 0 to 9 choose start, sample and stop conditions.
// - Trigger output pulses once per curve or once per stored point.
// - Trigger output polarity 0 gives rising, 1 gives falling edges.
// - Aux mode 0 converts on an internal tick, mode 1 on input pulses.
// - Aux mode 2 bursts the first input, mode 3 the first and second.
// - The storage interval is in us, floored at 1 fast or 1000 standard.
// - Status bit 5 flags new aux values after an external trigger.
`timescale 1ns/1ps
`include "curve_acq_defines.svh"

// ----------------------------------------------------------------------
// Sample FIFO
// ----------------------------------------------------------------------
module sample_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    // Full when pointers differ only in the wrap bit
    assign in_ready = !((wr_q[AW] != rd_q[AW]) &&
                        (wr_q[AW-1:0] == rd_q[AW-1:0]));
    assign out_valid = wr_q != rd_q;
    assign out_data = mem[rd_q[AW-1:0]];

    // Storage array
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(push);
            rd_q <= rd_q + (AW+1)'(pop);
        end
    end
endmodule

// ----------------------------------------------------------------------
// Acquisition control
// ----------------------------------------------------------------------
module curve_buffer_acquisition_trigger #(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 10,
    parameter int FIFO_DEPTH = 8,
    parameter int INTERVAL_W = 20,
    parameter int AUX_TICK_CYC = `AUX_TICK_CYCLES
) (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic TAKE_ONCE_CMD,
    input wire logic TAKE_CONTINUOUS_CMD,
    input wire logic CONT_PARAM_GIVEN,
    input wire logic [1:0] CONT_STOP_CODE,
    input wire logic TAKE_TRIGGERED_CMD,
    input wire logic [3:0] BUFFER_TRIGGER_INPUT_MODE,
    input wire logic HALT_CAPTURE_CMD,
    input wire logic [INTERVAL_W-1:0] STORAGE_INTERVAL,
    input wire logic FAST_MODE,
    input wire logic [ADDR_W:0] POINT_COUNT,
    input wire logic [3:0] SWEEP_LINK,
    input wire logic TRIGGER_OUTPUT_TYPE,
    input wire logic TRIGGER_OUTPUT_POLARITY,
    input wire logic [1:0] AUX_CONV_TRIGGER_MODE,
    input wire logic BUFFER_TRIGGER_INPUT,
    input wire logic AUX_CONV_TRIGGER_INPUT,
    input wire logic AUX_CONV_DONE,
    input wire logic STATUS_CLEAR,
    input wire logic [DATA_W-1:0] SAMPLE_DATA,
    input wire logic MEM_READY,
    output logic MEM_WE,
    output logic [ADDR_W-1:0] MEM_ADDR,
    output logic [DATA_W-1:0] MEM_WDATA,
    output logic TRIGGER_OUT,
    output logic SWEEP_START,
    output logic AUX_CONV_FIRST_START,
    output logic AUX_CONV_SECOND_START,
    output logic AUX_NEW_STATUS,
    output curve_acq_pkg::acq_state_t ACQ_STATE,
    output logic [ADDR_W:0] POINTS_STORED
);
    import curve_acq_pkg::*;

    localparam int US_CYC = `US_CYCLES;
    localparam int PW = $clog2(US_CYC + 1);
    localparam int AXW = $clog2(AUX_TICK_CYC + 1);
    localparam int BW = $clog2(`BURST_CYCLES + 1);
    localparam int TW = $clog2(`PULSE_CYCLES + 1);

    acq_state_t state_q, state_d;
    stop_kind_t stop_q;
    logic samp_ext_q, samp_fall_q, start_fall_q, pend_q;
    logic [1:0] sync1_q, sync2_q, sync3_q;
    logic [PW-1:0] presc_q;
    logic [INTERVAL_W-1:0] us_cnt_q;
    logic [ADDR_W:0] count_q;
    logic [ADDR_W-1:0] wptr_q;
    logic [TW-1:0] pulse_q, pulse_d;
    logic [AXW-1:0] aux_cnt_q;
    logic [BW-1:0] burst_q;
    logic ext_wait_q;
    logic fifo_in_ready, fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;

    // ------------------------------------------------------------------
    // Trigger pin synchronisers and edge detect
    // ------------------------------------------------------------------
    wire [1:0] pin_raw = {AUX_CONV_TRIGGER_INPUT, BUFFER_TRIGGER_INPUT};
    genvar g;
    for (g = 0; g < 2; g++) begin : g_sync
        // Two stages, then a delayed copy for edges
        always_ff @(posedge CLOCK or negedge RESET_N) begin
            if (!RESET_N) begin
                sync1_q[g] <= 1'b0;
                sync2_q[g] <= 1'b0;
                sync3_q[g] <= 1'b0;
            end else begin
                sync1_q[g] <= pin_raw[g];
                sync2_q[g] <= sync1_q[g];
                sync3_q[g] <= sync2_q[g];
            end
        end
    end
    wire buffer_trigger_input_rise = sync2_q[0] & ~sync3_q[0];
    wire buffer_trigger_input_fall = ~sync2_q[0] & sync3_q[0];
    wire adc_pulse = sync2_q[1] & ~sync3_q[1];

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    wire bare_cont = TAKE_CONTINUOUS_CMD & ~CONT_PARAM_GIVEN;
    wire cont_go = TAKE_CONTINUOUS_CMD & CONT_PARAM_GIVEN;
    wire [3:0] mode = bare_cont ? 4'h0 : BUFFER_TRIGGER_INPUT_MODE;
    wire buffer_trigger_input_go = (TAKE_TRIGGERED_CMD | bare_cont) &&
                   mode <= `BUFFER_TRIGGER_INPUT_MODE_MAX;
    wire not_run = state_q != ST_RUN;
    wire cmd_take = not_run & ~HALT_CAPTURE_CMD &
                    (TAKE_ONCE_CMD | cont_go | buffer_trigger_input_go);
    // Triggered mode fields
    wire m_samp_ext = mode[0] & ~mode[3];
    wire m_samp_fall = mode[0] & mode[1] & ~mode[3];
    wire m_start_ext = ~m_samp_ext;
    wire m_start_fall = (mode == 4'h9) |
                        (~mode[3] & mode[1] & ~mode[0]);
    wire stop_kind_t m_stop = mode[3] ? (mode[0] ? STOP_RISE : STOP_FALL)
                            : (mode[2] ? STOP_HALT : STOP_COUNT);
    wire stop_kind_t c_stop = CONT_STOP_CODE == 2'h1 ? STOP_RISE :
                            CONT_STOP_CODE == 2'h2 ? STOP_FALL :
                            STOP_HALT;
    wire use_buffer_trigger_input = ~TAKE_ONCE_CMD & ~cont_go;
    wire stop_kind_t cfg_stop = TAKE_ONCE_CMD ? STOP_COUNT :
                              cont_go ? c_stop : m_stop;
    wire cfg_samp_ext = use_buffer_trigger_input & m_samp_ext;
    wire cfg_wait = use_buffer_trigger_input & m_start_ext;

    // ------------------------------------------------------------------
    // Acquisition state machine
    // ------------------------------------------------------------------
    wire run = state_q == ST_RUN;
    wire start_edge = state_q == ST_ARMED &
                      (start_fall_q ? buffer_trigger_input_fall : buffer_trigger_input_rise);
    wire stop_edge = run & ((stop_q == STOP_RISE & buffer_trigger_input_rise) |
                            (stop_q == STOP_FALL & buffer_trigger_input_fall));
    wire store = run & pend_q & fifo_in_ready;
    wire last_pt = (count_q + 1'b1) >= POINT_COUNT;
    wire count_done = store & stop_q == STOP_COUNT & last_pt;

    // Next state, halt overrides everything
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE, ST_ARMED: begin
                if (cmd_take) begin
                    state_d = cfg_wait ? ST_ARMED : ST_RUN;
                end else if (start_edge) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (count_done || stop_edge) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (HALT_CAPTURE_CMD) begin
            state_d = ST_IDLE;
        end
    end
    wire run_entry = not_run & state_d == ST_RUN;

    // State and run configuration
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q <= ST_IDLE;
            stop_q <= STOP_COUNT;
            samp_ext_q <= 1'b0;
            samp_fall_q <= 1'b0;
            start_fall_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (cmd_take) begin
                stop_q <= cfg_stop;
                samp_ext_q <= cfg_samp_ext;
                samp_fall_q <= m_samp_fall;
                start_fall_q <= m_start_fall;
            end
        end
    end

    // ------------------------------------------------------------------
    // Point pacing
    // ------------------------------------------------------------------
    wire [INTERVAL_W-1:0] min_us = FAST_MODE ?
        INTERVAL_W'(`MIN_INTERVAL_FAST_US) :
        INTERVAL_W'(`MIN_INTERVAL_STD_US);
    wire [INTERVAL_W-1:0] interval = STORAGE_INTERVAL < min_us ?
        min_us : STORAGE_INTERVAL;
    wire stall = pend_q & ~fifo_in_ready;
    wire us_tick = run & ~stall & presc_q == PW'(US_CYC - 1);
    wire int_tick = us_tick & us_cnt_q == interval - 1'b1;
    wire samp_edge = run & samp_ext_q &
                     (samp_fall_q ? buffer_trigger_input_fall : buffer_trigger_input_rise);
    wire first_ext = cmd_take ? cfg_samp_ext : samp_ext_q;
    wire new_req = (run_entry & ~first_ext) |
                   (int_tick & ~samp_ext_q) | samp_edge;

    // Microsecond prescaler, interval counter and pending point
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            presc_q <= '0;
            us_cnt_q <= '0;
            pend_q <= 1'b0;
        end else begin
            if (!run || run_entry) begin
                presc_q <= '0;
            end else if (!stall) begin
                presc_q <= us_tick ? '0 : presc_q + 1'b1;
            end
            if (!run || int_tick) begin
                us_cnt_q <= '0;
            end else if (us_tick) begin
                us_cnt_q <= us_cnt_q + 1'b1;
            end
            pend_q <= (state_d == ST_RUN) & ((pend_q & ~store) | new_req);
        end
    end

    // ------------------------------------------------------------------
    // Sample FIFO and buffer write port
    // ------------------------------------------------------------------
    sample_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .in_valid(run & pend_q),
        .in_data(SAMPLE_DATA),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(MEM_READY)
    );
    wire pop = fifo_out_valid & MEM_READY;

    // Buffer writes; pointer keeps its place between runs
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            wptr_q <= '0;
            MEM_WE <= 1'b0;
            MEM_ADDR <= '0;
            MEM_WDATA <= '0;
            count_q <= '0;
        end else begin
            MEM_WE <= pop;
            if (pop) begin
                MEM_ADDR <= wptr_q;
                MEM_WDATA <= fifo_out_data;
                wptr_q <= wptr_q + 1'b1;
            end
            if (run_entry) begin
                count_q <= '0;
            end else if (store) begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Trigger output and sweep start
    // ------------------------------------------------------------------
    wire pulse_load = TRIGGER_OUTPUT_TYPE ? store : run_entry;
    always_comb begin
        pulse_d = '0;
        if (pulse_load) begin
            pulse_d = TW'(`PULSE_CYCLES);
        end else if (pulse_q != '0) begin
            pulse_d = pulse_q - 1'b1;
        end
    end
    wire link_ok = SWEEP_LINK >= `LINK_FIRST &&
                   SWEEP_LINK <= `LINK_LAST;

    // Pulse timer; active level set by polarity
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            pulse_q <= '0;
            TRIGGER_OUT <= 1'b0;
            SWEEP_START <= 1'b0;
        end else begin
            pulse_q <= pulse_d;
            TRIGGER_OUT <= TRIGGER_OUTPUT_POLARITY ^ (pulse_d != '0);
            SWEEP_START <= run_entry & link_ok;
        end
    end

    // ------------------------------------------------------------------
    // Auxiliary converter triggering
    // ------------------------------------------------------------------
    wire aux_tick = aux_cnt_q == AXW'(AUX_TICK_CYC - 1);
    wire burst_tick = burst_q == BW'(`BURST_CYCLES - 1);
    wire am_int = AUX_CONV_TRIGGER_MODE == 2'h0;
    wire am_ext = AUX_CONV_TRIGGER_MODE == 2'h1;
    wire am_burst = AUX_CONV_TRIGGER_MODE[1];
    wire conv_ext = am_ext & adc_pulse;
    wire conv_both = (am_int & aux_tick) | conv_ext;
    wire conv_burst = am_burst & run & burst_tick;
    wire status_set = AUX_CONV_DONE & ext_wait_q;

    // Tick counters, start strobes and new-value status
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            aux_cnt_q <= '0;
            burst_q <= '0;
            ext_wait_q <= 1'b0;
            AUX_CONV_FIRST_START <= 1'b0;
            AUX_CONV_SECOND_START <= 1'b0;
            AUX_NEW_STATUS <= 1'b0;
        end else begin
            aux_cnt_q <= aux_tick ? '0 : aux_cnt_q + 1'b1;
            burst_q <= (!run || burst_tick) ? '0 : burst_q + 1'b1;
            AUX_CONV_FIRST_START <= conv_both | conv_burst;
            AUX_CONV_SECOND_START <= conv_both |
                (conv_burst & AUX_CONV_TRIGGER_MODE[0]);
            ext_wait_q <= conv_ext | (ext_wait_q & ~AUX_CONV_DONE);
            AUX_NEW_STATUS <= status_set |
                (AUX_NEW_STATUS & ~STATUS_CLEAR);
        end
    end

    assign ACQ_STATE = state_q;
    assign POINTS_STORED = count_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESET_N);

    a_sweep_link_start: assert property (
        run_entry && link_ok |=> SWEEP_START)
        else $error("linked sweep not started");
    a_count_stop: assert property (
        count_done |=> ACQ_STATE == ST_IDLE && !pend_q)
        else $error("run did not stop at count");
    a_halt_stop: assert property (
        HALT_CAPTURE_CMD |=> ACQ_STATE == ST_IDLE && !pend_q)
        else $error("halt did not stop run");
    a_edge_stop: assert property (
        stop_edge && !HALT_CAPTURE_CMD |=> ACQ_STATE == ST_IDLE)
        else $error("stop edge ignored");
    a_bare_cont_arm: assert property (
        bare_cont && cmd_take |=> ACQ_STATE == ST_ARMED && !start_fall_q)
        else $error("bare continuous not mode 0");
    a_ptr_wrap: assert property (
        pop && wptr_q == '1 |=> wptr_q == '0 && MEM_ADDR == '1)
        else $error("write pointer did not wrap");
    a_armed_wait: assert property (
        state_q == ST_ARMED && !start_edge && !cmd_take |=>
        ACQ_STATE != ST_RUN)
        else $error("run began without trigger");
    a_point_pace: assert property (
        run && samp_ext_q && !pend_q && !samp_edge |=> !pend_q)
        else $error("per-point mode took an unpaced point");
    a_buffer_trigger_input_pulse: assert property (
        store && TRIGGER_OUTPUT_TYPE |=>
        TRIGGER_OUT != $past(TRIGGER_OUTPUT_POLARITY))
        else $error("no trigger pulse for point");
    a_ext_conv: assert property (
        conv_ext |=> AUX_CONV_FIRST_START && AUX_CONV_SECOND_START)
        else $error("external convert missed");
    a_burst_first: assert property (
        AUX_CONV_SECOND_START |-> $past(AUX_CONV_TRIGGER_MODE) != 2'h2)
        else $error("second input converted in mode 2");
    a_interval_floor: assert property (
        run |-> interval >= min_us)
        else $error("storage interval below floor");
    a_status_new: assert property (
        status_set |=> AUX_NEW_STATUS)
        else $error("status bit not set");

    c_once_run: cover property (count_done);
    c_armed_start: cover property (start_edge);
    c_fifo_full: cover property (run && !fifo_in_ready);
endmodule

// File: buffer_trigger_input_source_model.sv
// Far-side model: trigger pins, auxiliary converter and buffer memory.
// Assumes one clock shared with the block; pins move just after edges.
`timescale 1ns/1ps
module buffer_trigger_input_source_model #(
    parameter int DATA_W = 16,
    parameter int MIN_GAP = 10000
) (
    input wire logic clk,
    input wire logic slow,
    input wire logic conv_start,
    output logic buffer_trigger_input_pin,
    output logic aux_pin,
    output logic mem_ready,
    output logic conv_done,
    output logic [DATA_W-1:0] sample
);
    // ------------------------------------------------------------
    // Memory and converter answers
    // ------------------------------------------------------------
    logic [2:0] tick_q = 3'h0;
    logic [1:0] conv_q = 2'h0;
    initial begin
        buffer_trigger_input_pin = 1'b0;
        aux_pin = 1'b0;
        sample = '0;
    end
    // Converter answers two cycles after a start; data moves every cycle
    always @(posedge clk) begin
        tick_q <= tick_q + 3'h1;
        conv_q <= {conv_q[0], conv_start};
        sample <= sample + DATA_W'(1);
    end
    // When slow, memory refuses two cycles in every eight
    assign mem_ready = !slow || tick_q[2:1] != 2'h0;
    assign conv_done = conv_q[1];
    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    // Pin held long enough for the synchroniser to see both edges
    task automatic buffer_trigger_input_pulse(input int hi);
        @(posedge clk);
        #1 buffer_trigger_input_pin = 1'b1;
        repeat (hi) @(posedge clk);
        #1 buffer_trigger_input_pin = 1'b0;
    endtask
    // Sampling edges never faster than the maximum trigger rate
    task automatic sample_edge();
        repeat (MIN_GAP) @(posedge clk);
        buffer_trigger_input_pulse(5);
    endtask
    task automatic aux_pulse(input int hi);
        @(posedge clk);
        #1 aux_pin = 1'b1;
        repeat (hi) @(posedge clk);
        #1 aux_pin = 1'b0;
    endtask
endmodule

// File: curve_buffer_acquisition_trigger_bench.sv
// Self-checking bench for the curve buffer acquisition trigger block.
// Assumes the package, design files and far-side model compile first.
`timescale 1ns/1ps
module curve_buffer_acquisition_trigger_bench;
    import curve_acq_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clock = 1'b0, reset_n = 1'b0;
    logic once_c = 0, cont_c = 0, buffer_trigger_input_c = 0, halt_c = 0, clr = 0;
    logic given = 0, fast = 1, otype = 0, opol = 0, slow = 0;
    logic [1:0] code = 2'h0, amode = 2'h1;
    logic [3:0] mode = 4'h0, cnt = 4'h4, link = 4'h9, stored;
    logic [19:0] ival = 20'h3;
    logic tpin, apin, done, rdy, we, tout, sweep, s1, s2, astat;
    logic [15:0] sdata, wdata;
    logic [2:0] addr, last_a;
    acq_state_t st;
    logic prev_t = 1'b0;
    logic [15:0] last_d = 16'h0, gap_d = 16'h0;
    int wr_n = 0, trg_n = 0, sw_n = 0, s1_n = 0, s2_n = 0, base;
    int fails = 0, comparisons = 0;

    always #50 clock = ~clock;

    curve_buffer_acquisition_trigger #(.ADDR_W(3), .AUX_TICK_CYC(20))
    dut_u (.CLOCK(clock), .RESET_N(reset_n), .TAKE_ONCE_CMD(once_c),
        .TAKE_CONTINUOUS_CMD(cont_c), .CONT_PARAM_GIVEN(given),
        .CONT_STOP_CODE(code), .TAKE_TRIGGERED_CMD(buffer_trigger_input_c),
        .BUFFER_TRIGGER_INPUT_MODE(mode), .HALT_CAPTURE_CMD(halt_c),
        .STORAGE_INTERVAL(ival), .FAST_MODE(fast), .POINT_COUNT(cnt),
        .SWEEP_LINK(link), .TRIGGER_OUTPUT_TYPE(otype),
        .TRIGGER_OUTPUT_POLARITY(opol), .AUX_CONV_TRIGGER_MODE(amode),
        .BUFFER_TRIGGER_INPUT(tpin), .AUX_CONV_TRIGGER_INPUT(apin),
        .AUX_CONV_DONE(done), .STATUS_CLEAR(clr), .SAMPLE_DATA(sdata),
        .MEM_READY(rdy), .MEM_WE(we), .MEM_ADDR(addr), .MEM_WDATA(wdata),
        .TRIGGER_OUT(tout), .SWEEP_START(sweep),
        .AUX_CONV_FIRST_START(s1), .AUX_CONV_SECOND_START(s2),
        .AUX_NEW_STATUS(astat), .ACQ_STATE(st), .POINTS_STORED(stored));

    buffer_trigger_input_source_model src_u (.clk(clock), .slow(slow), .conv_start(s1),
        .buffer_trigger_input_pin(tpin), .aux_pin(apin), .mem_ready(rdy),
        .conv_done(done), .sample(sdata));

    // Counts writes, sweep and converter starts, active trigger edges
    always @(posedge clock) begin
        if (we === 1'b1) begin
            wr_n++;
            last_a = addr;
            gap_d = wdata - last_d;
            last_d = wdata;
        end
        sw_n += (sweep === 1'b1);
        s1_n += (s1 === 1'b1);
        s2_n += (s2 === 1'b1);
        trg_n += (tout !== prev_t && tout === !opol);
        prev_t = tout;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // One-cycle command pulse, taken at the edge before return
    task automatic cmd(ref logic c);
        @(posedge clock);
        #1 c = 1'b1;
        @(posedge clock);
        #1 c = 1'b0;
    endtask
    task automatic wait_st(input logic [1:0] s, input int lim);
        int n;
        n = 0;
        while (st !== s && n < lim) begin
            @(posedge clock);
            #1 n++;
        end
        if (n == lim) begin
            fails++;
            $display("MISMATCH state expected %0h seen %0h", s, st);
            test_done();
        end
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clock);
        #1 reset_n = 1'b1;
        // Once: four points from the start of the buffer
        cmd(once_c);
        chk("state", ST_RUN, st);
        wait_st(ST_IDLE, 2000);
        repeat (12) @(posedge clock);
        chk("writes", 4, wr_n);
        chk("stored", 4, stored);
        chk("sweep starts", 1, sw_n);
        chk("trigger pulses", 1, trg_n);
        chk("last address", 3, last_a);
        chk("data step", 30, gap_d);
        $display("test once done");
        // Triggered mode 0: arm, start on rising edge, continue position
        cmd(buffer_trigger_input_c);
        chk("state", ST_ARMED, st);
        src_u.buffer_trigger_input_pulse(20);
        chk("state", ST_RUN, st);
        wait_st(ST_IDLE, 2000);
        repeat (12) @(posedge clock);
        chk("writes", 8, wr_n);
        chk("last address", 7, last_a);
        chk("sweep starts", 2, sw_n);
        $display("test triggered done");
        // Continuous code 1, per-point falling pulses, stalling memory
        #1;
        given = 1'b1;
        code = 2'h1;
        otype = 1'b1;
        opol = 1'b1;
        amode = 2'h3;
        slow = 1'b1;
        repeat (4) @(posedge clock);
        trg_n = 0;
        base = wr_n;
        cmd(cont_c);
        chk("state", ST_RUN, st);
        repeat (300) @(posedge clock);
        src_u.buffer_trigger_input_pulse(8);
        chk("state", ST_IDLE, st);
        repeat (12) @(posedge clock);
        chk("trigger pulses", wr_n - base, trg_n);
        chk("last address", (wr_n - 1) % 8, last_a);
        chk("wrapped", 1, wr_n > 16);
        chk("second starts", 1, s2_n > 0);
        $display("test continuous done");
        // Bare continuous arms as mode 0; halt; mode 10 refused
        given = 1'b0;
        cmd(cont_c);
        chk("state", ST_ARMED, st);
        cmd(halt_c);
        chk("state", ST_IDLE, st);
        mode = 4'ha;
        cmd(buffer_trigger_input_c);
        chk("state", ST_IDLE, st);
        $display("test refusal done");
        // Mode 5: one point per rising edge, interval ignored, halt stops
        mode = 4'h5;
        cmd(buffer_trigger_input_c);
        chk("state", ST_RUN, st);
        src_u.sample_edge();
        src_u.sample_edge();
        repeat (12) @(posedge clock);
        chk("stored", 2, stored);
        cmd(halt_c);
        chk("state", ST_IDLE, st);
        $display("test per point done");
        // Aux converter: external start sets status, clear, internal tick
        amode = 2'h1;
        src_u.aux_pulse(5);
        for (int i = 0; i < 20 && astat !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        chk("aux status", 1, astat);
        cmd(clr);
        @(posedge clock);
        #1;
        chk("aux status", 0, astat);
        amode = 2'h0;
        s1_n = 0;
        repeat (100) @(posedge clock);
        chk("internal ticks", 1, s1_n >= 4 && s1_n <= 6);
        $display("test aux done");
        test_done();
    end
endmodule
